// File: design/bfs_defs.svh
// timing constants and power-good codes for the buck fault supervisor
`ifndef BFS_DEFS_SVH
`define BFS_DEFS_SVH
`define BFS_CLK_MHZ        50
`define BFS_OC_QUAL_NS     10000
`define BFS_OV_FILT_NS     2000
`define BFS_UV_FILT_NS     2000
`define BFS_START_DLY_NS   20000
`define BFS_OC_QUAL_CYC    ((`BFS_OC_QUAL_NS * `BFS_CLK_MHZ) / 1000)
`define BFS_OV_FILT_CYC    ((`BFS_OV_FILT_NS * `BFS_CLK_MHZ) / 1000)
`define BFS_UV_FILT_CYC    ((`BFS_UV_FILT_NS * `BFS_CLK_MHZ) / 1000)
`define BFS_START_DLY_CYC  ((`BFS_START_DLY_NS * `BFS_CLK_MHZ) / 1000)
`define BFS_PG_HIGHZ       2'h0
`define BFS_PG_UV          2'h1
`define BFS_PG_OV          2'h2
`define BFS_PG_OC          2'h3
`endif

// File: design/bfs_pkg.sv
// types for the buck fault supervisor
package bfs_pkg;
    typedef enum logic [1:0] {
        BFS_OFF   = 2'h0,
        BFS_DELAY = 2'h1,
        BFS_SLEW  = 2'h3,
        BFS_RUN   = 2'h2
    } bfs_seq_e;
    // power-good pull-down code: 0 open, 1 uv/soft-start, 2 ov, 3 oc
    typedef logic [1:0] bfs_pg_t;
endpackage : bfs_pkg

// File: design/bfs_filter.sv
// qualification filter: condition must hold a full interval uninterrupted
`timescale 1ns/1ps
`default_nettype none
module bfs_filter #(
    parameter int CYCLES = 100
) (
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic cond,
    output var  logic qualified
);
    localparam int W = $clog2(CYCLES + 1);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         done;

    assign done  = (cnt_q == W'(CYCLES));
    // counter restarts on any drop of the condition
    assign cnt_d = !cond ? '0 : (done ? cnt_q : cnt_q + W'(1));

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            cnt_q     <= '0;
            qualified <= 1'b0;
        end
        else
        begin
            cnt_q     <= cnt_d;
            qualified <= cond && done;
        end
    end
endmodule : bfs_filter
`default_nettype wire

// File: design/bfs_supervisor.sv
// buck fault supervisor: start-up sequencing, fault latches, power-good coding
`timescale 1ns/1ps
`include "bfs_defs.svh"
`default_nettype none
module bfs_supervisor #(
    parameter int OC_QUAL_CYC   = `BFS_OC_QUAL_CYC,
    parameter int OV_FILT_CYC   = `BFS_OV_FILT_CYC,
    parameter int UV_FILT_CYC   = `BFS_UV_FILT_CYC,
    parameter int START_DLY_CYC = `BFS_START_DLY_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        bias_por_ok,
    input  wire logic        enable_in,
    input  wire logic        current_over_output,
    input  wire logic        overvoltage_rise_level,
    input  wire logic        overvoltage_fall_level,
    input  wire logic        undervoltage_level,
    input  wire logic        overheat_rise_level,
    input  wire logic        overheat_hysteresis,
    input  wire logic        soft_start_taper,
    output var  logic        soft_start_clamp_release,
    output var  logic        reference_amp_enable,
    output var  logic        soft_start_reference_slew,
    output var  logic        soft_start_done_flag,
    output var  logic        power_good_out,
    output var  bfs_pkg::bfs_pg_t power_good_code,
    output var  logic        pwm_run,
    output var  logic        diode_emulation,
    output var  logic        continuous_conduction,
    output var  logic        low_side_gate_force_on,
    output var  logic        gates_force_low,
    output var  logic        overcurrent_fault,
    output var  logic        overvoltage_fault,
    output var  logic        undervoltage_fault,
    output var  logic        overheat_state
);
    import bfs_pkg::*;

    // pin-level comparator outputs are asynchronous: two-stage synchronisers
    logic [7:0] sync1_q;
    logic [7:0] sync2_q;
    logic [7:0] async_in;
    assign async_in = {soft_start_taper, overheat_hysteresis, overheat_rise_level,
                       undervoltage_level, overvoltage_fall_level,
                       overvoltage_rise_level, current_over_output, enable_in};

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            sync1_q <= 8'h00;
            sync2_q <= 8'h00;
        end
        else
        begin
            sync1_q <= async_in;
            sync2_q <= sync1_q;
        end
    end

    // bias por detector is the reset source; bias_por_ok also synchronised
    logic bias1_q;
    logic bias2_q;
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            bias1_q <= 1'b0;
            bias2_q <= 1'b0;
        end
        else
        begin
            bias1_q <= bias_por_ok;
            bias2_q <= bias1_q;
        end
    end

    logic en_s;
    logic oc_s;
    logic ovr_s;
    logic ovf_s;
    logic uv_s;
    logic otr_s;
    logic oth_s;
    logic taper_s;
    assign en_s    = sync2_q[0];
    assign oc_s    = sync2_q[1];
    assign ovr_s   = sync2_q[2];
    // fall comparator high means feedback is still above the falling level
    assign ovf_s   = sync2_q[3];
    assign uv_s    = sync2_q[4];
    assign otr_s   = sync2_q[5];
    // hysteresis comparator high means still above the release temperature
    assign oth_s   = sync2_q[6];
    assign taper_s = sync2_q[7];

    // enable low or bias loss clears resettable latches
    logic bias_lost;
    logic en_clear;
    assign bias_lost = !bias2_q;
    assign en_clear  = !en_s || bias_lost;

    // qualification filters
    logic oc_qual;
    logic ov_qual;
    logic ovlow_qual;
    logic uv_qual;

    bfs_filter #(.CYCLES(OC_QUAL_CYC)) u_oc_filt (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .cond      (oc_s),
        .qualified (oc_qual)
    );
    bfs_filter #(.CYCLES(OV_FILT_CYC)) u_ov_filt (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .cond      (ovr_s),
        .qualified (ov_qual)
    );
    bfs_filter #(.CYCLES(OV_FILT_CYC)) u_ovlow_filt (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .cond      (!ovf_s),
        .qualified (ovlow_qual)
    );
    // undervoltage only meaningful once reference is live; gated by sequencing
    bfs_filter #(.CYCLES(UV_FILT_CYC)) u_uv_filt (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .cond      (uv_s),
        .qualified (uv_qual)
    );

    // start-up sequencer
    localparam int SW = $clog2(START_DLY_CYC + 1);
    bfs_seq_e      seq_q;
    bfs_seq_e      seq_d;
    logic [SW-1:0] dly_q;
    logic [SW-1:0] dly_d;
    logic          dly_done;
    logic          go;

    assign go       = en_s && bias2_q;
    assign dly_done = (dly_q == SW'(START_DLY_CYC));

    // slew and run both mean the reference is live;
    // used for fault arming and for switching permission
    function automatic logic bfs_live(input bfs_seq_e s);
        return (s == BFS_SLEW) || (s == BFS_RUN);
    endfunction : bfs_live

    always_comb
    begin
        seq_d = seq_q;
        dly_d = dly_q;
        unique case (seq_q)
            BFS_OFF:
            begin
                dly_d = '0;
                if (go)
                    seq_d = BFS_DELAY;
            end
            BFS_DELAY:
            begin
                dly_d = dly_q + SW'(1);
                if (dly_done)
                    seq_d = BFS_SLEW;
            end
            BFS_SLEW:
            begin
                if (taper_s)
                    seq_d = BFS_RUN;
            end
            BFS_RUN:
            begin
                seq_d = BFS_RUN;
            end
        endcase
        if (!go)
            seq_d = BFS_OFF;
    end

    // fault latches
    logic oc_q;
    logic ov_q;
    logic uv_q;
    logic ot_q;
    logic lg_on_q;
    logic armed;
    // oc, ov and uv faults only detected once the converter has begun regulating
    assign armed = bfs_live(seq_q);

    logic oc_d;
    logic ov_d;
    logic uv_d;
    logic ot_d;
    logic lg_on_d;
    assign oc_d = en_clear ? 1'b0 : (oc_q || (armed && oc_qual));
    // ov clears on bias loss only; enable is ignored
    assign ov_d = bias_lost ? 1'b0 : (ov_q || (armed && ov_qual));
    // detectors not gated by over-temperature state
    assign uv_d = en_clear ? 1'b0 : (uv_q || (armed && uv_qual));
    assign ot_d = en_clear ? 1'b0
                : (ot_q ? oth_s : otr_s);
    // low-side discharge toggles while latched: on after rise, off after fall
    assign lg_on_d = !ov_d ? 1'b0
                   : (ov_qual ? 1'b1 : (ovlow_qual ? 1'b0 : lg_on_q));

    // first fault owns the power-good code
    bfs_pg_t code_q;
    bfs_pg_t code_d;
    logic    any_latched;
    logic    none_before;
    assign any_latched = oc_d || ov_d || uv_d;
    assign none_before = !(oc_q || ov_q || uv_q);

    always_comb
    begin
        code_d = code_q;
        if (!any_latched)
            code_d = (seq_d == BFS_RUN) ? `BFS_PG_HIGHZ : `BFS_PG_UV;
        else if (none_before)
        begin
            // simultaneous first faults: overcurrent over overvoltage over uv
            if (oc_d)
                code_d = `BFS_PG_OC;
            else if (ov_d)
                code_d = `BFS_PG_OV;
            else
                code_d = `BFS_PG_UV;
        end
    end

    logic latched_off;
    assign latched_off = oc_d || ov_d || uv_d;

    // from next state so an enable drop stops switching on the same edge
    logic run_ok;
    assign run_ok = bfs_live(seq_d) && !latched_off && !ot_d;
    // over-temperature beats the overvoltage discharge path
    logic lg_drive;
    assign lg_drive = lg_on_d && !ot_d;

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            seq_q   <= BFS_OFF;
            dly_q   <= '0;
            oc_q    <= 1'b0;
            ov_q    <= 1'b0;
            uv_q    <= 1'b0;
            ot_q    <= 1'b0;
            lg_on_q <= 1'b0;
            code_q  <= `BFS_PG_UV;
        end
        else
        begin
            seq_q   <= seq_d;
            dly_q   <= dly_d;
            oc_q    <= oc_d;
            ov_q    <= ov_d;
            uv_q    <= uv_d;
            ot_q    <= ot_d;
            lg_on_q <= lg_on_d;
            code_q  <= code_d;
        end
    end

    // registered outputs, computed from next-state so they align with latches
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            soft_start_clamp_release  <= 1'b0;
            reference_amp_enable      <= 1'b0;
            soft_start_reference_slew <= 1'b0;
            soft_start_done_flag      <= 1'b0;
            power_good_out            <= 1'b0;
            power_good_code           <= `BFS_PG_UV;
            pwm_run                   <= 1'b0;
            diode_emulation           <= 1'b0;
            continuous_conduction     <= 1'b1;
            low_side_gate_force_on    <= 1'b0;
            gates_force_low           <= 1'b1;
            overcurrent_fault         <= 1'b0;
            overvoltage_fault         <= 1'b0;
            undervoltage_fault        <= 1'b0;
            overheat_state            <= 1'b0;
        end
        else
        begin
            soft_start_clamp_release  <= seq_d != BFS_OFF;
            reference_amp_enable      <= seq_d != BFS_OFF;
            soft_start_reference_slew <= bfs_live(seq_d);
            soft_start_done_flag      <= seq_d == BFS_RUN;
            // over-temperature leaves power-good untouched
            power_good_out            <= code_d == `BFS_PG_HIGHZ;
            power_good_code           <= code_d;
            // switching permission taken from next state
            pwm_run                   <= run_ok;
            diode_emulation           <= (seq_d == BFS_RUN) && !latched_off;
            continuous_conduction     <= seq_d != BFS_RUN;
            // over-temperature forces both gates low, overriding discharge
            low_side_gate_force_on    <= lg_drive;
            gates_force_low           <= !run_ok && !lg_drive;
            overcurrent_fault         <= oc_d;
            overvoltage_fault         <= ov_d;
            undervoltage_fault        <= uv_d;
            overheat_state            <= ot_d;
        end
    end
endmodule : bfs_supervisor
`default_nettype wire

// File: bench/bfs_properties.sv
// assertion checker for the buck fault supervisor ports
`timescale 1ns/1ps
`default_nettype none
module bfs_properties #(
    parameter int OC_QUAL_CYC   = 500,
    parameter int START_DLY_CYC = 1000
) (
    input wire logic             clk_sys,
    input wire logic             reset,
    input wire logic             bias_por_ok,
    input wire logic             current_over_output,
    input wire logic             soft_start_clamp_release,
    input wire logic             soft_start_reference_slew,
    input wire logic             soft_start_done_flag,
    input wire logic             power_good_out,
    input wire bfs_pkg::bfs_pg_t power_good_code,
    input wire logic             pwm_run,
    input wire logic             diode_emulation,
    input wire logic             low_side_gate_force_on,
    input wire logic             gates_force_low,
    input wire logic             overcurrent_fault,
    input wire logic             overvoltage_fault,
    input wire logic             undervoltage_fault,
    input wire logic             overheat_state
);
    import bfs_pkg::*;
    int         oc_run_q;
    int         rel_q;
    logic [3:0] bias_lo_q;
    logic       any_fault;
    assign any_fault = overcurrent_fault | overvoltage_fault | undervoltage_fault;
    // raw pin run lengths; the design adds sync latency on top
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            oc_run_q  <= 0;
            rel_q     <= 0;
            bias_lo_q <= 4'h0;
        end
        else
        begin
            oc_run_q  <= current_over_output ? oc_run_q + 1 : 0;
            rel_q     <= soft_start_clamp_release ? rel_q + 1 : 0;
            bias_lo_q <= {bias_lo_q[2:0], ~bias_por_ok};
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    pg_open_a: assert property (power_good_out |-> soft_start_done_flag && !any_fault)
        else $error("power good released outside run");
    dem_gate_a: assert property (diode_emulation |-> soft_start_done_flag)
        else $error("diode emulation before soft-start done");
    ss_code_a: assert property (soft_start_clamp_release && !soft_start_done_flag && !any_fault
        |-> power_good_code == 2'h1 && !power_good_out)
        else $error("wrong power good code in soft-start");
    oc_filter_a: assert property ($rose(overcurrent_fault) |-> $past(oc_run_q, 2) >= OC_QUAL_CYC)
        else $error("overcurrent latched before qualification");
    slew_delay_a: assert property ($rose(soft_start_reference_slew) |-> rel_q >= START_DLY_CYC - 1)
        else $error("reference slew started early");
    oc_off_a: assert property (overcurrent_fault |=> !pwm_run && !power_good_out)
        else $error("converter running with overcurrent latched");
    ov_keep_a: assert property ($fell(overvoltage_fault) |-> |bias_lo_q)
        else $error("overvoltage cleared without bias loss");
    lsg_cause_a: assert property (low_side_gate_force_on |-> overvoltage_fault)
        else $error("low-side discharge without overvoltage latch");
    ot_gates_a: assert property (overheat_state ##1 overheat_state |-> gates_force_low && !pwm_run)
        else $error("gates not held low in over-temperature");
    first_code_a: assert property (overvoltage_fault && $past(overvoltage_fault)
        && $past(power_good_code) == 2'h2 |-> power_good_code == 2'h2)
        else $error("first fault code replaced");
endmodule : bfs_properties
bind bfs_supervisor bfs_properties #(.OC_QUAL_CYC(OC_QUAL_CYC), .START_DLY_CYC(START_DLY_CYC))
    u_props (.clk_sys, .reset, .bias_por_ok, .current_over_output, .soft_start_clamp_release,
    .soft_start_reference_slew, .soft_start_done_flag, .power_good_out, .power_good_code,
    .pwm_run, .diode_emulation, .low_side_gate_force_on, .gates_force_low, .overcurrent_fault,
    .overvoltage_fault, .undervoltage_fault, .overheat_state);
`default_nettype wire

// File: bench/bfs_frontend.sv
// comparator front end standing in for the analog sense circuits
`timescale 1ns/1ps
`default_nettype none
module bfs_frontend (
    input  wire logic       clk_sys,
    input  wire logic       soft_start_reference_slew,
    input  wire logic [7:0] fb_pct,
    input  wire logic [7:0] temp_c,
    input  wire logic       oc_sense,
    output var  logic       current_over_output,
    output var  logic       overvoltage_rise_level,
    output var  logic       overvoltage_fall_level,
    output var  logic       undervoltage_level,
    output var  logic       overheat_rise_level,
    output var  logic       overheat_hysteresis,
    output var  logic       soft_start_taper
);
    int ss_q = 0;
    // taper only once the reference has slewed a while; drops when slew stops
    always @(posedge clk_sys)
        ss_q <= soft_start_reference_slew ? ss_q + 1 : 0;
    assign soft_start_taper       = ss_q > 30;
    assign current_over_output    = oc_sense;
    assign overvoltage_rise_level = fb_pct > 8'h74;
    assign overvoltage_fall_level = fb_pct > 8'h66;
    assign undervoltage_level     = fb_pct < 8'h54;
    assign overheat_rise_level    = temp_c > 8'h96;
    assign overheat_hysteresis    = temp_c > 8'h7D;
endmodule : bfs_frontend
`default_nettype wire

// File: bench/tb.sv
// self-checking bench for the buck fault supervisor
`timescale 1ns/1ps
`default_nettype none
module tb;
    import bfs_pkg::*;
    localparam int OC = 8;
    localparam int FLT = 4;
    logic clk_sys, reset = 1'b1, bias_por_ok = 1'b0, enable_in = 1'b0, oc_sense = 1'b0;
    logic [7:0] fb_pct = 8'h64, temp_c = 8'h19;
    logic current_over_output, overvoltage_rise_level, overvoltage_fall_level;
    logic undervoltage_level, overheat_rise_level, overheat_hysteresis, soft_start_taper;
    logic soft_start_clamp_release, reference_amp_enable, soft_start_reference_slew;
    logic soft_start_done_flag, power_good_out, pwm_run, diode_emulation;
    logic continuous_conduction, low_side_gate_force_on, gates_force_low;
    logic overcurrent_fault, overvoltage_fault, undervoltage_fault, overheat_state;
    bfs_pg_t power_good_code;
    int num_errors = 0, n_compared = 0, cyc = 0, i, n;
    bfs_supervisor #(.OC_QUAL_CYC(OC), .OV_FILT_CYC(FLT), .UV_FILT_CYC(FLT),
        .START_DLY_CYC(10)) DUT (.clk_sys, .reset, .bias_por_ok, .enable_in,
        .current_over_output, .overvoltage_rise_level, .overvoltage_fall_level,
        .undervoltage_level, .overheat_rise_level, .overheat_hysteresis, .soft_start_taper,
        .soft_start_clamp_release, .reference_amp_enable, .soft_start_reference_slew,
        .soft_start_done_flag, .power_good_out, .power_good_code, .pwm_run, .diode_emulation,
        .continuous_conduction, .low_side_gate_force_on, .gates_force_low,
        .overcurrent_fault, .overvoltage_fault, .undervoltage_fault, .overheat_state);
    bfs_frontend FE (.clk_sys, .soft_start_reference_slew, .fb_pct, .temp_c, .oc_sense,
        .current_over_output, .overvoltage_rise_level, .overvoltage_fall_level,
        .undervoltage_level, .overheat_rise_level, .overheat_hysteresis, .soft_start_taper);
    function automatic logic trips(input int len, input int limit);
        return len > limit;
    endfunction : trips
    task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic step(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : step
    task automatic power_up();
        bias_por_ok = 1'b1;
        enable_in = 1'b1;
        wait (soft_start_done_flag === 1'b1);
        step(1);
    endtask : power_up
    task automatic complete_run();
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // a hang anywhere is cut short here
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc > 20000)
        begin
            num_errors++;
            complete_run();
        end
    end
    initial
    begin
        void'($urandom(94));
        step(20);
        reset = 1'b0;
        enable_in = 1'b1;
        step(10);
        chk(soft_start_clamp_release, 1'b0);
        bias_por_ok = 1'b1;
        wait (soft_start_clamp_release === 1'b1);
        step(1);
        chk({reference_amp_enable, soft_start_reference_slew, power_good_code}, 4'h9);
        wait (soft_start_reference_slew === 1'b1);
        step(1);
        chk({continuous_conduction, diode_emulation}, 2'b10);
        wait (soft_start_done_flag === 1'b1);
        step(1);
        chk({power_good_out, diode_emulation, power_good_code}, 4'hC);
        // short excursions of random kind must all be filtered out
        for (i = 0; i < 40; i++)
        begin
            n = $urandom_range(FLT, 1);
            case ($urandom_range(2, 0))
                0: oc_sense = 1'b1;
                1: fb_pct = 8'h78;
                default: fb_pct = 8'h50;
            endcase
            step(n);
            oc_sense = 1'b0;
            fb_pct = 8'h55 + 8'($urandom_range(30, 0));
            step($urandom_range(3, 1));
        end
        step(5);
        chk({overcurrent_fault, overvoltage_fault, undervoltage_fault}, {2'b00, trips(n, FLT)});
        fb_pct = 8'h78;
        wait (overvoltage_fault === 1'b1);
        step(1);
        chk({pwm_run, power_good_out, power_good_code}, 4'h2);
        chk(low_side_gate_force_on, 1'b1);
        fb_pct = 8'h6E;
        step(20);
        chk(low_side_gate_force_on, 1'b1);
        fb_pct = 8'h64;
        step(FLT);
        chk(low_side_gate_force_on, 1'b1);
        wait (low_side_gate_force_on === 1'b0);
        #1;
        fb_pct = 8'h78;
        step(FLT);
        chk(low_side_gate_force_on, 1'b0);
        wait (low_side_gate_force_on === 1'b1);
        #1;
        fb_pct = 8'h64;
        oc_sense = 1'b1;
        step(OC + 10);
        chk(power_good_code, 2'h2);
        oc_sense = 1'b0;
        enable_in = 1'b0;
        step(20);
        chk({overvoltage_fault, power_good_code}, 4'h6);
        bias_por_ok = 1'b0;
        wait (overvoltage_fault === 1'b0);
        step(1);
        chk({overcurrent_fault, low_side_gate_force_on}, 2'b00);
        power_up();
        oc_sense = 1'b1;
        step(OC);
        chk(overcurrent_fault, 1'b0);
        wait (overcurrent_fault === 1'b1);
        step(1);
        chk({pwm_run, power_good_out, power_good_code}, 4'h3);
        fb_pct = 8'h50;
        step(20);
        chk(power_good_code, 2'h3);
        fb_pct = 8'h64;
        oc_sense = 1'b0;
        enable_in = 1'b0;
        wait (overcurrent_fault === 1'b0);
        step(1);
        chk(undervoltage_fault, 1'b0);
        power_up();
        temp_c = 8'hA0;
        wait (overheat_state === 1'b1);
        step(1);
        chk({gates_force_low, pwm_run}, 2'b10);
        chk({power_good_out, power_good_code, overcurrent_fault}, 4'h8);
        temp_c = 8'h8C;
        step(20);
        chk(overheat_state, 1'b1);
        temp_c = 8'h64;
        wait (overheat_state === 1'b0);
        step(1);
        chk(pwm_run, 1'b1);
        temp_c = 8'hA0;
        wait (overheat_state === 1'b1);
        #1;
        fb_pct = 8'h50;
        wait (undervoltage_fault === 1'b1);
        step(1);
        chk({overheat_state, power_good_code}, 4'h5);
        fb_pct = 8'h64;
        enable_in = 1'b0;
        step(20);
        chk({overheat_state, undervoltage_fault}, 2'b00);
        complete_run();
    end
endmodule : tb
`default_nettype wire
